/* design/ebi_core.sv */
// External bus interface: address forming, bus cycles, byte enables, sizing
//
// Summary of operation
// - High byte write enable is bus high enable ORed with write strobe.
// - Low byte write enable is address bit zero ORed with write strobe.
// - High enable goes with data lines 15..8, low enable with 7..0.
// - Byte write enables and write byte output float during reset.
// - Narrow variant asserts write byte for each write, with address bus timing.
// - Write strobe marks writes; floats during bus hold or reset.
// - Physical address is segment shifted left four plus offset, 20 bits.
// - Segment chosen from reference kind: code, data, stack, extra.
// - I/O space of 64K byte ports, from 8-bit operand or port index.
// - An 8-bit port operand is zero extended, address 15..8 low.
// - Multiplexed bus carries address in T1 only; address bus holds T1..T4.
// - Address disable floats multiplexed bus in address phase for that space.
// - Narrow variant drives upper address outputs in every data phase.
// - Strap low at reset ignores both disable bits; address always multiplexed.
// - Strap sampled on the fourth clock edge after reset release; its pin is never driven.
// - Address bus valid half a bus clock before address on multiplexed bus.
// - With address disable, multiplexed lines carry only data.
// - Narrow variant is all 8-bit; wide variant sizes from configuration.
// - Upper space 16 bits on the wide variant; other size fields: 0 wide, 1 narrow.
`include "ebi_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module ebi_core
    import ebi_pkg::*;
#(
    parameter bit          WIDE_BUS   = 1'b1,
    parameter logic [19:0] UPPER_BASE = 20'hF0000,
    parameter logic [19:0] LOWER_TOP  = 20'h0FFFF
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        req_valid,
    input  wire bus_req_t    req,
    input  wire seg_regs_t   segs,
    input  wire bus_cfg_t    cfg,
    input  wire logic        bus_hold,
    input  wire logic        emulation_float_mode,
    input  wire logic        address_enable_strap,
    input  wire logic [15:0] ad_i,
    output logic             req_ready,
    output logic             done,
    output logic [15:0]      rdata,
    output logic             bus_output_clock,
    output logic [19:0]      addr_o,
    output logic             addr_oe_n,
    output logic [15:0]      ad_o,
    output logic [1:0]       ad_oe_n,
    output logic [7:0]       upper_addr_outputs,
    output logic             upper_addr_oe_n,
    output logic             wr_n,
    output logic             bus_high_enable_n,
    output logic             high_byte_write_enable_n,
    output logic             low_byte_write_enable_n,
    output logic             byte_write_output_n,
    output logic             strobe_oe_n,
    output logic             strap_oe_n
);
    bus_state_t  st_q, st_d;
    logic        ph_q, ph_d;
    logic [19:0] cur_addr_q;
    logic [15:0] wdata_q;
    logic        write_q, word_q, split_q, second_q, narrow_q, da_q;
    logic        hold_s1, hold_s2, hold_s3, hold_q;
    logic        strap_s1, strap_s2, strap_s3, strap_q, strap_done_q;
    logic [1:0]  strap_cnt_q;
    logic [15:0] seg_c, port_c;
    logic [19:0] phys_c;
    logic        upper_c, lower_c, narrow_c, start_c, last_c, lane_hi, full_word;
    logic        in_data, wr_d, bhe_d, float_all;

    // Pin inputs: three flops, a bus_hold change counts once stages two and three agree
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_s1  <= 1'b0;
            hold_s2  <= 1'b0;
            hold_s3  <= 1'b0;
            hold_q   <= 1'b0;
            strap_s1 <= 1'b1;
            strap_s2 <= 1'b1;
            strap_s3 <= 1'b1;
        end else if (ce) begin
            hold_s1  <= bus_hold;
            hold_s2  <= hold_s1;
            hold_s3  <= hold_s2;
            strap_s1 <= address_enable_strap;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            if (hold_s2 == hold_s3) begin
                hold_q <= hold_s3;
            end
        end
    end

    // Strap caught after release, never during the async reset itself
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strap_cnt_q  <= 2'h0;
            strap_done_q <= 1'b0;
            strap_q      <= 1'b0;
        end else if (ce && !strap_done_q) begin
            // Extra two edges let the pin synchroniser flush its reset value
            if (strap_cnt_q < 2'(`STRAP_SAMPLE_CYCLES + 2)) begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
            end else if (strap_s2 == strap_s3) begin
                strap_q      <= strap_s3;
                strap_done_q <= 1'b1;
            end
        end
    end

    always_comb begin
        case (req.kind)
            REF_FETCH:      seg_c = segs.code_seg;
            REF_STACK:      seg_c = segs.stack_seg;
            REF_BASE_PTR:   seg_c = segs.stack_seg;
            REF_STRING_DST: seg_c = segs.extra_segment;
            default:        seg_c = segs.data_segment;
        endcase
    end

    // 8-bit operand zero extended; full 64K port range otherwise
    assign port_c  = req.io_imm ? {`IO_IMM_HIGH_ZERO, req.port_imm}
                                : req.port_index_register;
    assign phys_c  = req.is_io ? {4'h0, port_c}
                   : ({seg_c, {`SEG_SHIFT_BITS{1'b0}}} + {4'h0, req.offset});
    assign upper_c = !req.is_io && (phys_c >= UPPER_BASE);
    assign lower_c = !req.is_io && !upper_c && (phys_c <= LOWER_TOP);

    // Upper space never narrow on the wide part
    always_comb begin
        if (!WIDE_BUS) begin
            narrow_c = 1'b1;
        end else if (req.is_io) begin
            narrow_c = cfg.io_space_size == `SIZE_NARROW;
        end else if (upper_c) begin
            narrow_c = `SIZE_WIDE;
        end else if (lower_c) begin
            narrow_c = cfg.lower_space_size == `SIZE_NARROW;
        end else begin
            narrow_c = cfg.other_space_size == `SIZE_NARROW;
        end
    end

    assign start_c   = req_valid && req_ready;
    assign last_c    = !split_q || second_q;
    assign lane_hi   = WIDE_BUS && !narrow_q && cur_addr_q[0];
    assign full_word = word_q && !split_q;

    always_comb begin
        st_d = st_q;
        ph_d = ph_q;
        case (st_q)
            ST_IDLE: begin
                if (start_c) begin
                    st_d = ST_LEAD;
                end
            end
            ST_LEAD: begin
                st_d = ST_T1;
                ph_d = 1'b0;
            end
            ST_T1: begin
                ph_d = !ph_q;
                if (ph_q) begin
                    st_d = ST_T2;
                end
            end
            ST_T2: begin
                ph_d = !ph_q;
                if (ph_q) begin
                    st_d = ST_T3;
                end
            end
            ST_T3: begin
                ph_d = !ph_q;
                if (ph_q) begin
                    st_d = ST_T4;
                end
            end
            ST_T4: begin
                ph_d = !ph_q;
                if (ph_q) begin
                    st_d = last_c ? ST_IDLE : ST_LEAD;
                end
            end
            default: begin
                st_d = ST_IDLE;
                ph_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            ph_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            ph_q <= ph_d;
        end
    end

    // Request capture; a second byte cycle reuses the capture, address plus one
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur_addr_q <= 20'h00000;
            wdata_q    <= 16'h0000;
            write_q    <= 1'b0;
            word_q     <= 1'b0;
            split_q    <= 1'b0;
            second_q   <= 1'b0;
            narrow_q   <= 1'b0;
            da_q       <= 1'b0;
        end else if (ce) begin
            if (start_c) begin
                cur_addr_q <= phys_c;
                wdata_q    <= req.wdata;
                write_q    <= req.write;
                word_q     <= req.word;
                narrow_q   <= narrow_c;
                split_q    <= req.word && (narrow_c || phys_c[0]);
                second_q   <= 1'b0;
                da_q       <= strap_q && ((upper_c && cfg.upper_address_disable_bit)
                           || (lower_c && cfg.lower_address_disable_bit));
            end else if (st_q == ST_T4 && ph_q && !last_c) begin
                cur_addr_q <= cur_addr_q + 20'h00001;
                second_q   <= 1'b1;
            end
        end
    end

    // Read data sampled at the close of T3; bus is synchronous to bus_output_clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0000;
            done  <= 1'b0;
        end else if (ce) begin
            done <= st_q == ST_T4 && ph_q && last_c;
            if (st_q == ST_T3 && ph_q && !write_q) begin
                if (full_word) begin
                    rdata <= ad_i;
                end else if (second_q) begin
                    rdata[15:8] <= narrow_q ? ad_i[7:0] : ad_i[15:8];
                end else begin
                    rdata[7:0] <= lane_hi ? ad_i[15:8] : ad_i[7:0];
                end
            end
        end
    end

    assign in_data   = st_d == ST_T2 || st_d == ST_T3 || st_d == ST_T4;
    assign wr_d      = !(write_q && (st_d == ST_T2 || st_d == ST_T3));
    assign bhe_d     = (st_d == ST_IDLE) || !(full_word || lane_hi);
    assign float_all = hold_q || emulation_float_mode;

    // Pin drivers, registered from next-state values so pins line up with st_q
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            req_ready                <= 1'b0;
            bus_output_clock         <= 1'b0;
            addr_o                   <= 20'h00000;
            addr_oe_n                <= 1'b1;
            ad_o                     <= 16'h0000;
            ad_oe_n                  <= 2'h3;
            upper_addr_outputs       <= 8'h00;
            upper_addr_oe_n          <= 1'b1;
            wr_n                     <= 1'b1;
            bus_high_enable_n        <= 1'b1;
            high_byte_write_enable_n <= 1'b1;
            low_byte_write_enable_n  <= 1'b1;
            byte_write_output_n      <= 1'b1;
            strobe_oe_n              <= 1'b1;
            strap_oe_n               <= 1'b1;
        end else if (ce) begin
            req_ready        <= st_d == ST_IDLE && !float_all && strap_done_q && !start_c;
            bus_output_clock <= st_d != ST_LEAD && (st_d == ST_IDLE ? !bus_output_clock : !ph_d);
            strap_oe_n       <= 1'b1;
            if (start_c) begin
                addr_o <= phys_c;
            end else if (st_q == ST_T4 && ph_q && !last_c) begin
                addr_o <= cur_addr_q + 20'h00001;
            end
            addr_oe_n        <= float_all && st_d == ST_IDLE;
            strobe_oe_n      <= float_all && st_d == ST_IDLE;
            ad_o             <= 16'h0000;
            ad_oe_n          <= 2'h3;
            if (st_d == ST_T1 && !da_q) begin
                ad_o    <= WIDE_BUS ? cur_addr_q[15:0] : {8'h00, cur_addr_q[7:0]};
                ad_oe_n <= WIDE_BUS ? 2'h0 : 2'h2;
            end else if (in_data && write_q) begin
                if (full_word) begin
                    ad_o    <= wdata_q;
                    ad_oe_n <= 2'h0;
                end else if (lane_hi) begin
                    ad_o    <= {wdata_q[7:0], 8'h00};
                    ad_oe_n <= 2'h1;
                end else begin
                    ad_o    <= {8'h00, second_q ? wdata_q[15:8] : wdata_q[7:0]};
                    ad_oe_n <= 2'h2;
                end
            end
            upper_addr_outputs <= cur_addr_q[15:8];
            upper_addr_oe_n    <= WIDE_BUS || !((st_d == ST_T1 && !da_q) || in_data);
            wr_n               <= wr_d;
            bus_high_enable_n  <= bhe_d;
            if (WIDE_BUS) begin
                high_byte_write_enable_n <= bhe_d | wr_d;
                low_byte_write_enable_n  <= cur_addr_q[0] | wr_d;
                byte_write_output_n      <= 1'b1;
            end else begin
                high_byte_write_enable_n <= 1'b1;
                low_byte_write_enable_n  <= 1'b1;
                byte_write_output_n      <= !(write_q && st_d != ST_IDLE
                                           && st_d != ST_T4);
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_high_we_or: assert property (WIDE_BUS |-> high_byte_write_enable_n == (bus_high_enable_n | wr_n))
        else $error("high byte write enable differs from bhe or wr");
    a_low_we_or: assert property ((WIDE_BUS && st_q != ST_IDLE) |-> low_byte_write_enable_n == (addr_o[0] | wr_n))
        else $error("low byte write enable differs from a0 or wr");
    a_hold_float: assert property ((st_q == ST_IDLE && hold_q && ce) |=> strobe_oe_n && addr_oe_n)
        else $error("strobes driven during bus hold");
    a_addr_form: assert property (start_c && ce |=> cur_addr_q == $past(phys_c))
        else $error("physical address not latched from segment and offset");
    a_io_zext: assert property (start_c && ce && req.is_io && req.io_imm |=> cur_addr_q[19:8] == 12'h000)
        else $error("8-bit port not zero extended");
    a_abus_stable: assert property ((st_q inside {ST_LEAD, ST_T1, ST_T2, ST_T3}) |=> $stable(addr_o))
        else $error("address bus changed inside a bus cycle");
    a_da_floats: assert property ((st_q == ST_T1 && da_q) |-> ad_oe_n == 2'h3)
        else $error("multiplexed bus driven in address phase with disable");
    a_strap_low: assert property ((st_q == ST_T1 && strap_done_q && !strap_q) |-> !ad_oe_n[0])
        else $error("address missing from multiplexed bus with strap low");
    a_lead_half: assert property ((st_q == ST_LEAD && ce) |=> st_q == ST_T1 && $stable(addr_o))
        else $error("address bus lead over T1 not one half period");
    a_upper_data: assert property ((!WIDE_BUS && st_q inside {ST_T2, ST_T3, ST_T4}) |-> !upper_addr_oe_n)
        else $error("upper address outputs floated in data phase");
    a_split_two: assert property ((st_q == ST_T4 && ph_q && split_q && !second_q && ce) |=> st_q == ST_LEAD)
        else $error("split word did not start a second byte cycle");

    c_write: cover property (st_q == ST_T2 && write_q && full_word);
    c_read: cover property (done && !write_q);
    c_split: cover property (st_q == ST_T1 && second_q && narrow_q);
    c_disable: cover property (st_q == ST_T1 && da_q);
endmodule
`default_nettype wire

/* design/ebi_pkg.sv */
// Types shared by the external bus interface
package ebi_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_LEAD = 6'h02,
        ST_T1   = 6'h04,
        ST_T2   = 6'h08,
        ST_T3   = 6'h10,
        ST_T4   = 6'h20
    } bus_state_t;

    typedef enum logic [2:0] {
        REF_FETCH      = 3'h0,
        REF_DATA       = 3'h1,
        REF_STACK      = 3'h2,
        REF_BASE_PTR   = 3'h3,
        REF_STRING_DST = 3'h4
    } ref_kind_t;

    typedef struct packed {
        logic [15:0] code_seg;
        logic [15:0] data_segment;
        logic [15:0] stack_seg;
        logic [15:0] extra_segment;
    } seg_regs_t;

    typedef struct packed {
        logic        is_io;
        logic        io_imm;
        logic        write;
        logic        word;
        ref_kind_t   kind;
        logic [15:0] offset;
        logic [7:0]  port_imm;
        logic [15:0] port_index_register;
        logic [15:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic upper_address_disable_bit;
        logic lower_address_disable_bit;
        logic lower_space_size;
        logic io_space_size;
        logic other_space_size;
    } bus_cfg_t;
endpackage

/* design/ebi_regs.svh */
// Timing and field constants of the external bus interface
`ifndef EBI_REGS_SVH
`define EBI_REGS_SVH
`define SEG_SHIFT_BITS      4
`define IO_IMM_HIGH_ZERO    8'h00
`define CLK_PERIOD_NS       10
`define STRAP_DELAY_NS      10
`define STRAP_SAMPLE_CYCLES ((`STRAP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SIZE_WIDE           1'h0
`define SIZE_NARROW         1'h1
`endif

/* dv/ext_mem.sv */
// Behavioural byte-wide memory standing on the far side of the bus
`timescale 1ns/10ps
`default_nettype none
module ext_mem (
    input  wire logic [19:0] addr_o,
    input  wire logic [15:0] ad_o,
    input  wire logic [1:0]  ad_oe_n,
    input  wire logic        hb_we_n,
    input  wire logic        lb_we_n,
    input  wire logic        narrow,
    output logic [15:0]      ad_i
);
    logic [7:0] mem [256];
    logic [7:0] a_e;

    assign a_e = {addr_o[7:1], 1'h0};

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end

    // Odd byte lives on lane 15..8, even byte on lane 7..0
    always @(posedge hb_we_n) begin
        mem[a_e | 8'h01] <= ad_o[15:8];
    end
    always @(posedge lb_we_n) begin
        mem[a_e] <= ad_o[7:0];
    end

    // Width is set by the bench between accesses only
    always_comb begin
        if (ad_oe_n != 2'h3) begin
            // Contention shows as inverted data, never the last value
            ad_i = ~ad_o;
        end else if (narrow) begin
            ad_i = {~mem[addr_o[7:0]], mem[addr_o[7:0]]};
        end else begin
            ad_i = {mem[a_e | 8'h01], mem[a_e]};
        end
    end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the external bus interface
`timescale 1ns/10ps
`default_nettype none
module tb_top import ebi_pkg::*;;
    logic        clk_sys, rst, bus_hold, strap, narrow, req_valid;
    bus_req_t    req;
    seg_regs_t   segs;
    bus_cfg_t    cfg;
    wire logic [15:0] ad_i;
    logic        req_ready, done, bclk, addr_oe_n, wr_n, bhe_n, hb_n, lb_n, wb_n, strobe_oe_n;
    logic [15:0] rdata, ad_o;
    logic [19:0] addr_o;
    logic [1:0]  ad_oe_n;
    logic [19:0] s_addr [21];
    logic [15:0] s_ad [21];
    logic [1:0]  s_oe [21];
    logic        s_wr [21], s_hb [21], s_lb [21], s_bhe [21], s_dn [21], s_bc [21];
    int          fail_count = 0;
    int          tests_run = 0;
    logic [15:0] seg_of [5] = '{16'h1000, 16'h2000, 16'h3000, 16'h3000, 16'h4000};

    ebi_core dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'h1), .req_valid(req_valid),
        .req(req), .segs(segs), .cfg(cfg), .bus_hold(bus_hold),
        .emulation_float_mode(1'h0), .address_enable_strap(strap), .ad_i(ad_i),
        .req_ready(req_ready), .done(done), .rdata(rdata), .bus_output_clock(bclk),
        .addr_o(addr_o), .addr_oe_n(addr_oe_n), .ad_o(ad_o), .ad_oe_n(ad_oe_n),
        .upper_addr_outputs(), .upper_addr_oe_n(), .wr_n(wr_n), .bus_high_enable_n(bhe_n),
        .high_byte_write_enable_n(hb_n), .low_byte_write_enable_n(lb_n),
        .byte_write_output_n(wb_n), .strobe_oe_n(strobe_oe_n), .strap_oe_n());

    ext_mem mem_u (.addr_o(addr_o), .ad_o(ad_o), .ad_oe_n(ad_oe_n), .hb_we_n(hb_n),
        .lb_we_n(lb_n), .narrow(narrow), .ad_i(ad_i));

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string m, input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Take one request and record the pins for 21 cycles after the take edge
    task automatic access(input bus_req_t r, input bus_cfg_t c);
        int n;
        n = 0;
        while (req_ready !== 1'h1 && n < 100) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        req = r;
        cfg = c;
        req_valid = 1'h1;
        @(posedge clk_sys);
        #1;
        req_valid = 1'h0;
        for (int i = 0; i < 21; i++) begin
            {s_addr[i], s_ad[i], s_oe[i], s_wr[i]} = {addr_o, ad_o, ad_oe_n, wr_n};
            {s_hb[i], s_lb[i], s_bhe[i], s_dn[i], s_bc[i]} = {hb_n, lb_n, bhe_n, done, bclk};
            if (i < 20) begin
                @(posedge clk_sys);
                #1;
            end
        end
    endtask

    task automatic do_reset(input logic st);
        @(posedge clk_sys);
        #1;
        rst = 1'h1;
        strap = st;
        repeat (2) @(posedge clk_sys);
        chk("reset ad oe", 20'(ad_oe_n), 20'h3);
        chk("reset strobe oe", 20'(strobe_oe_n), 20'h1);
        chk("reset ready", 20'(req_ready), 20'h0);
        repeat (2) @(posedge clk_sys);
        #1;
        rst = 1'h0;
    endtask

    task automatic t_segments();
        bus_req_t r;
        logic [19:0] ea;
        for (int k = 0; k < 5; k++) begin
            r = '0;
            r.write = 1'h1;
            r.word = 1'h1;
            r.kind = ref_kind_t'(3'(k));
            r.offset = 16'h1234;
            r.wdata = 16'hC300 + 16'(k);
            ea = {seg_of[k], 4'h0} + 20'h01234;
            access(r, '0);
            chk("lead addr", s_addr[0], ea);
            chk("lead clk", 20'(s_bc[0]), 20'h0);
            chk("lead ad", 20'(s_oe[0]), 20'h3);
            chk("t1 ad", 20'(s_ad[2]), 20'(ea[15:0]));
            chk("t1 oe", 20'(s_oe[2]), 20'h0);
            chk("t4 addr", s_addr[8], ea);
            chk("t2 data", 20'(s_ad[4]), 20'(r.wdata));
            chk("t2 wr", 20'(s_wr[4]), 20'h0);
            chk("t2 hb", 20'(s_hb[4]), 20'h0);
            chk("t2 lb", 20'(s_lb[4]), 20'h0);
            chk("t4 hb", 20'(s_hb[8]), 20'h1);
            chk("done", 20'(s_dn[9]), 20'h1);
            r.write = 1'h0;
            access(r, '0);
            chk("readback", 20'(rdata), 20'(16'hC300 + 16'(k)));
        end
    endtask

    task automatic t_byte_odd();
        bus_req_t r;
        r = '0;
        r.write = 1'h1;
        r.kind = REF_DATA;
        r.offset = 16'h1235;
        r.wdata = 16'h0077;
        access(r, '0);
        chk("odd hb", 20'(s_hb[4]), 20'(s_bhe[4] | s_wr[4]));
        chk("odd hb low", 20'(s_hb[4]), 20'h0);
        chk("odd lb", 20'(s_lb[4]), 20'h1);
    endtask

    task automatic t_io();
        bus_req_t r;
        r = '0;
        r.is_io = 1'h1;
        r.io_imm = 1'h1;
        r.port_imm = 8'hF7; // Kept below the reserved ports
        r.port_index_register = 16'hFFFF;
        access(r, '0);
        chk("io imm", 20'(s_addr[1][15:0]), 20'h000F7);
        r.io_imm = 1'h0;
        r.port_index_register = 16'hABCE;
        access(r, '0);
        chk("io idx", 20'(s_addr[1][15:0]), 20'h0ABCE);
    endtask

    task automatic t_narrow();
        bus_req_t r;
        bus_cfg_t c;
        r = '0;
        r.word = 1'h1;
        r.kind = REF_DATA;
        r.offset = 16'h1240;
        c = '0;
        c.other_space_size = 1'h1;
        narrow = 1'h1;
        access(r, c);
        narrow = 1'h0;
        chk("split lo", s_addr[1], 20'h21240);
        chk("split hi", s_addr[10], 20'h21241);
        chk("split mid", 20'(s_dn[10]), 20'h0);
        chk("split done", 20'(s_dn[18]), 20'h1);
        chk("split data", 20'(rdata), 20'h01B1A);
    endtask

    task automatic t_disable(input logic st);
        bus_req_t r;
        bus_cfg_t c;
        r = '0;
        r.kind = REF_FETCH;
        r.offset = 16'h0010;
        c = '0;
        c.upper_address_disable_bit = 1'h1;
        segs.code_seg = 16'hF000;
        access(r, c);
        segs.code_seg = 16'h1000;
        chk("da addr", s_addr[2], 20'hF0010);
        chk("da t1", 20'(s_oe[2]), st ? 20'h3 : 20'h0);
    endtask

    task automatic t_hold();
        @(posedge clk_sys);
        #1;
        bus_hold = 1'h1;
        repeat (8) @(posedge clk_sys);
        chk("hold strobe", 20'(strobe_oe_n), 20'h1);
        chk("hold ready", 20'(req_ready), 20'h0);
        #1;
        bus_hold = 1'h0;
    endtask

    initial begin
        {rst, bus_hold, narrow, req_valid} = 4'h8;
        strap = 1'h1;
        req = '0;
        cfg = '0;
        segs = '{16'h1000, 16'h2000, 16'h3000, 16'h4000};
        do_reset(1'h1);
        t_segments();
        t_byte_odd();
        t_io();
        t_narrow();
        t_hold();
        t_disable(1'h1);
        do_reset(1'h0);
        t_disable(1'h0);
        results();
    end

    // Whole run needs a few hundred cycles; this is far beyond it
    initial begin
        #500000;
        fail_count++;
        results();
    end
endmodule
`default_nettype wire
